// *** common/ubh_consts.vh ***
`ifndef UBH_CONSTS_VH
`define UBH_CONSTS_VH
// ==========================================================================
// Handshake bytes
// ==========================================================================
`define UBH_BYTE_START      8'h55
`define UBH_BYTE_ACK        8'haa
`define UBH_BYTE_NAK        8'hff
`define UBH_BYTE_ERASE_POLL 8'h3a
`define UBH_BYTE_ERASE_BUSY 8'h11
`define UBH_BYTE_ERASE_DONE 8'h06
`define UBH_BYTE_ERASE_FAIL 8'hee
// ==========================================================================
// Mode pins and clock information
// ==========================================================================
`define UBH_MODE_X3         3'h3
`define UBH_MODE_X2         3'h2
`define UBH_FREQ_16MHZ      16'h0640
`define UBH_FREQ_24MHZ      16'h0960
`define UBH_MUL_CLASS       8'h01
`define UBH_MUL_RATIO       8'h01
`define UBH_STRAP_SETTLE    2'h3
// ==========================================================================
// Enumeration information
// ==========================================================================
`define UBH_USB_VERSION     16'h0110
`define UBH_EP0_PACKET      7'h40
`define UBH_CONFIG_NUM      8'h01
`define UBH_IFACE_NUM       8'h00
`define UBH_ALT_SETTING     8'h00
`define UBH_POWER_SELF      9'h064
`define UBH_POWER_BUS       9'h1f4
// ==========================================================================
// RAM areas
// ==========================================================================
`define UBH_PROG_BASE       24'hffc000
`define UBH_PROG_BASE_SMALL 24'hffd000
`define UBH_PROG_MAX        16'h2000
`define UBH_PROG_MAX_SMALL  16'h1000
`define UBH_BOOT_RAM_LO     24'hffe000
`define UBH_BOOT_RAM_HI     24'hffefbf
// ==========================================================================
// Register map (byte addresses) and resets
// ==========================================================================
`define UBH_REG_FREQ_TOL    8'h00
`define UBH_REG_STATUS      8'h04
`define UBH_REG_RX_FREQ     8'h08
`define UBH_REG_PROG_COUNT  8'h0c
`define UBH_FREQ_TOL_RESET  16'h0000
`endif

// *** src/ubh_boot_handshake.v ***
// Operation
// R1: Host straps write enable 1, mode 011 for 16 MHz, times-three multiplier.
// R2: Host straps write enable 1, mode 010 for 24 MHz, times-two multiplier.
// R3: D+ pull-up is driven only from the dedicated pull-up pin.
// R4: Power select 1 reports self-powered 100 mA, 0 bus-powered 500 mA.
// R5: Enumerate USB 1.1: 64-byte control, bulk in, bulk out, config 1.
// R6: Bus-powered boot never enters power-down on USB suspend.
// R7: Host sends one start byte 55 after enumeration.
// R8: Device answers start byte 55 with a single AA.
// R9: Host resets the device if the start handshake fails.
// R10: Host sends 2-byte frequency, class byte, ratio byte, both 01.
// R11: Frequency field is MHz times 100: 0640 or 0960.
// R12: Clock information checked: AA if all in range, else FF and stop.
// R13: Two-byte count N: AA if in range, else FF and stop.
// R14: Program stored from FFC000, or FFD000 on small-RAM parts.
// R15: Erase all flash blocks when flash holds programmed data.
// R16: After transfer, branch to program area start address.
// R17: USB connection stays active after the branch.
// R18: Loaded program initialises registers and stack pointer itself.
// R19: Leaving boot: reset low 20 states, set pins, then release.
// R20: Watchdog overflow reset also leaves boot mode.
// R21: Mode pins stay constant throughout boot mode.
// R22: Interrupts stay unusable while flash erase is in progress.
// R23: Program plus checksum summed: AA if zero, else FF and stop.
// R24: Erase poll 3A answered 11 busy, 06 done, EE fail and stop.
// R25: Host waits for each acknowledge before the next phase.
`timescale 1ns/10ps
`include "ubh_consts.vh"

module ubh_boot_handshake (
  input  wire        SYS_CLK,
  input  wire        ARST_N,
  input  wire        FLASH_WRITE_ENABLE_PIN,
  input  wire [2:0]  MODE_SELECT_PINS,
  input  wire        USB_POWER_MODE_SELECT,
  input  wire        SMALL_RAM,
  input  wire        USB_ENUMERATED,
  input  wire [7:0]  RX_DATA,
  input  wire        RX_VALID,
  output wire        RX_READY,
  output reg  [7:0]  TX_DATA,
  output reg         TX_VALID,
  input  wire        TX_READY,
  output reg  [23:0] RAM_ADDR,
  output reg  [7:0]  RAM_WDATA,
  output reg         RAM_WE,
  input  wire        FLASH_BLANK,
  output reg         FLASH_ERASE_START,
  input  wire        FLASH_ERASE_DONE,
  input  wire        FLASH_ERASE_FAIL,
  output wire        INT_DISABLE,
  output reg         BRANCH_REQ,
  output reg  [23:0] BRANCH_ADDR,
  input  wire        WATCHDOG_TIMER_OVERFLOW,
  output wire        BOOT_ACTIVE,
  output wire        PULLUP_CONTROL_PORT_PIN,
  output wire        TIMES_THREE_MULTIPLIER,
  output wire        TIMES_TWO_MULTIPLIER,
  output wire        SELF_POWERED,
  output wire [8:0]  MAX_POWER_MA,
  output wire        POWER_DOWN_INHIBIT,
  output wire [15:0] USB_VERSION,
  output wire [6:0]  CTRL_EP_MAX_PACKET,
  output wire [7:0]  CONFIG_NUMBER,
  output wire [7:0]  INTERFACE_NUMBER,
  output wire [7:0]  ALT_SETTING,
  input  wire [7:0]  REG_ADDR,
  input  wire [31:0] REG_WDATA,
  input  wire        REG_WR,
  input  wire        REG_RD,
  output reg  [31:0] REG_RDATA
);

  // ========================================================================
  // States
  // ========================================================================
  localparam [3:0] S_WAIT_ENUM  = 4'h0;
  localparam [3:0] S_WAIT_START = 4'h1;
  localparam [3:0] S_SEND       = 4'h2;
  localparam [3:0] S_CLKINFO    = 4'h3;
  localparam [3:0] S_CHK_CLK    = 4'h4;
  localparam [3:0] S_COUNT      = 4'h5;
  localparam [3:0] S_CHK_CNT    = 4'h6;
  localparam [3:0] S_PROG       = 4'h7;
  localparam [3:0] S_SUM        = 4'h8;
  localparam [3:0] S_ERASE      = 4'h9;
  localparam [3:0] S_BRANCH     = 4'ha;
  localparam [3:0] S_RUN        = 4'hb;
  localparam [3:0] S_HALT       = 4'hc;
  localparam [3:0] S_EXIT       = 4'hd;

  // ========================================================================
  // Pin synchronisers and strap capture
  // ========================================================================
  reg [5:0] pin_meta;
  reg [5:0] pin_sync;
  reg [1:0] settle;
  reg       strap_valid;
  reg       strap_fwe;
  reg [2:0] strap_mode;
  reg       strap_self;
  reg       strap_small;

  always @(posedge SYS_CLK or negedge ARST_N) begin
    if (!ARST_N) begin
      pin_meta <= 6'h00;
      pin_sync <= 6'h00;
    end else begin
      pin_meta <= {SMALL_RAM, USB_POWER_MODE_SELECT, FLASH_WRITE_ENABLE_PIN,
                   MODE_SELECT_PINS};
      pin_sync <= pin_meta;
    end
  end

  // Straps are caught once after the synchronisers fill, so pin movement
  // later in boot mode cannot change the clocking or the RAM layout.
  always @(posedge SYS_CLK or negedge ARST_N) begin
    if (!ARST_N) begin
      settle      <= 2'h0;
      strap_valid <= 1'b0;
      strap_fwe   <= 1'b0;
      strap_mode  <= 3'h0;
      strap_self  <= 1'b0;
      strap_small <= 1'b0;
    end else if (!strap_valid) begin
      settle <= settle + 2'h1;
      if (settle == `UBH_STRAP_SETTLE) begin
        strap_valid <= 1'b1;
        strap_fwe   <= pin_sync[3];
        strap_mode  <= pin_sync[2:0];
        strap_self  <= pin_sync[4];
        strap_small <= pin_sync[5];
      end
    end
  end

  wire mode_x3   = strap_fwe && (strap_mode == `UBH_MODE_X3); // R1
  wire mode_x2   = strap_fwe && (strap_mode == `UBH_MODE_X2); // R2
  wire boot_mode = strap_valid && (mode_x3 || mode_x2);

  // ========================================================================
  // Handshake sequencer
  // ========================================================================
  reg [3:0]  state;
  reg [3:0]  ret_state;
  reg [15:0] byte_idx;
  reg [15:0] rx_freq;
  reg [7:0]  rx_class;
  reg [7:0]  rx_ratio;
  reg [15:0] prog_count;
  reg [7:0]  sum;
  reg        erasing;
  reg        erase_done;
  reg        erase_fail;
  reg        exited;
  reg [15:0] freq_tol;

  wire [15:0] freq_nom  = mode_x3 ? `UBH_FREQ_16MHZ : `UBH_FREQ_24MHZ; // R11
  // Distance from nominal is taken on the ordered pair, so no tolerance can wrap.
  wire [15:0] freq_dist = (rx_freq >= freq_nom) ? rx_freq - freq_nom : freq_nom - rx_freq;
  wire        freq_ok   = (freq_dist <= freq_tol);
  wire        clk_ok    = freq_ok && (rx_class == `UBH_MUL_CLASS)
                          && (rx_ratio == `UBH_MUL_RATIO); // R12
  wire [15:0] prog_max  = strap_small ? `UBH_PROG_MAX_SMALL : `UBH_PROG_MAX;
  wire [23:0] prog_base = strap_small ? `UBH_PROG_BASE_SMALL : `UBH_PROG_BASE; // R14
  wire        cnt_ok    = (prog_count != 16'h0000) && (prog_count <= prog_max); // R13
  wire [7:0]  sum_total = sum + RX_DATA;

  assign RX_READY = (state == S_WAIT_START) || (state == S_CLKINFO) ||
                    (state == S_COUNT) || (state == S_PROG) ||
                    (state == S_SUM) || (state == S_ERASE);
  wire rx_take = RX_VALID && RX_READY;

  always @(posedge SYS_CLK or negedge ARST_N) begin
    if (!ARST_N) begin
      state             <= S_WAIT_ENUM;
      ret_state         <= S_WAIT_ENUM;
      byte_idx          <= 16'h0000;
      rx_freq           <= 16'h0000;
      rx_class          <= 8'h00;
      rx_ratio          <= 8'h00;
      prog_count        <= 16'h0000;
      sum               <= 8'h00;
      erasing           <= 1'b0;
      erase_done        <= 1'b0;
      erase_fail        <= 1'b0;
      exited            <= 1'b0;
      TX_DATA           <= 8'h00;
      TX_VALID          <= 1'b0;
      RAM_ADDR          <= 24'h000000;
      RAM_WDATA         <= 8'h00;
      RAM_WE            <= 1'b0;
      FLASH_ERASE_START <= 1'b0;
      BRANCH_REQ        <= 1'b0;
      BRANCH_ADDR       <= 24'h000000;
    end else begin
      RAM_WE            <= 1'b0;
      FLASH_ERASE_START <= 1'b0;
      BRANCH_REQ        <= 1'b0;
      if (erasing && FLASH_ERASE_DONE) begin
        erase_done <= 1'b1;
      end
      if (erasing && FLASH_ERASE_FAIL) begin
        erase_fail <= 1'b1;
      end
      if (WATCHDOG_TIMER_OVERFLOW) begin
        // Watchdog overflow ends boot mode for good until the next reset.
        exited   <= 1'b1; // R20
        TX_VALID <= 1'b0;
        state    <= S_EXIT; // R20
      end else begin
        case (state)
          S_WAIT_ENUM: begin
            if (boot_mode && USB_ENUMERATED) begin
              state <= S_WAIT_START;
            end
          end
          S_WAIT_START: begin
            // Any other byte is dropped; the host recovers by a reset.
            if (rx_take && (RX_DATA == `UBH_BYTE_START)) begin
              TX_DATA   <= `UBH_BYTE_ACK; // R8
              TX_VALID  <= 1'b1;
              ret_state <= S_CLKINFO;
              byte_idx  <= 16'h0000;
              state     <= S_SEND;
            end
          end
          S_SEND: begin
            if (TX_READY) begin
              TX_VALID <= 1'b0;
              state    <= ret_state;
            end
          end
          S_CLKINFO: begin
            if (rx_take) begin
              byte_idx <= byte_idx + 16'h0001;
              case (byte_idx[1:0])
                2'h0:    rx_freq[15:8] <= RX_DATA;
                2'h1:    rx_freq[7:0]  <= RX_DATA;
                2'h2:    rx_class      <= RX_DATA;
                default: begin
                  rx_ratio <= RX_DATA;
                  state    <= S_CHK_CLK;
                end
              endcase
            end
          end
          S_CHK_CLK: begin
            TX_DATA   <= clk_ok ? `UBH_BYTE_ACK : `UBH_BYTE_NAK; // R12
            TX_VALID  <= 1'b1;
            ret_state <= clk_ok ? S_COUNT : S_HALT;
            byte_idx  <= 16'h0000;
            state     <= S_SEND;
          end
          S_COUNT: begin
            if (rx_take) begin
              byte_idx <= byte_idx + 16'h0001;
              if (byte_idx[0] == 1'b0) begin
                prog_count[15:8] <= RX_DATA;
              end else begin
                prog_count[7:0] <= RX_DATA;
                state           <= S_CHK_CNT;
              end
            end
          end
          S_CHK_CNT: begin
            TX_DATA   <= cnt_ok ? `UBH_BYTE_ACK : `UBH_BYTE_NAK; // R13
            TX_VALID  <= 1'b1;
            ret_state <= cnt_ok ? S_PROG : S_HALT;
            byte_idx  <= 16'h0000;
            sum       <= 8'h00;
            state     <= S_SEND;
          end
          S_PROG: begin
            if (rx_take) begin
              RAM_ADDR  <= prog_base + {8'h00, byte_idx}; // R14
              RAM_WDATA <= RX_DATA;
              RAM_WE    <= 1'b1;
              sum       <= sum_total;
              byte_idx  <= byte_idx + 16'h0001;
              if (byte_idx == prog_count - 16'h0001) begin
                state <= S_SUM;
              end
            end
          end
          S_SUM: begin
            if (rx_take) begin
              TX_VALID <= 1'b1;
              state    <= S_SEND;
              if (sum_total == 8'h00) begin
                TX_DATA   <= `UBH_BYTE_ACK; // R23
                ret_state <= S_ERASE;
                erasing   <= 1'b1;
                // A blank array needs no erase and reports done at once.
                erase_done        <= FLASH_BLANK; // R15
                FLASH_ERASE_START <= !FLASH_BLANK; // R15
              end else begin
                TX_DATA   <= `UBH_BYTE_NAK; // R23
                ret_state <= S_HALT;
              end
            end
          end
          S_ERASE: begin
            if (rx_take && (RX_DATA == `UBH_BYTE_ERASE_POLL)) begin
              TX_VALID <= 1'b1;
              state    <= S_SEND;
              if (erase_fail || FLASH_ERASE_FAIL) begin
                TX_DATA   <= `UBH_BYTE_ERASE_FAIL; // R24
                ret_state <= S_HALT;
              end else if (erase_done || FLASH_ERASE_DONE) begin
                TX_DATA   <= `UBH_BYTE_ERASE_DONE; // R24
                ret_state <= S_BRANCH;
              end else begin
                TX_DATA   <= `UBH_BYTE_ERASE_BUSY; // R24
                ret_state <= S_ERASE;
              end
            end
          end
          S_BRANCH: begin
            erasing     <= 1'b0;
            BRANCH_ADDR <= prog_base; // R16
            BRANCH_REQ  <= 1'b1; // R16
            state       <= S_RUN;
          end
          S_RUN: begin
            state <= S_RUN; // R17
          end
          S_HALT, S_EXIT: begin
            state <= state;
          end
          default: begin
            state <= S_HALT;
          end
        endcase
      end
    end
  end

  // ========================================================================
  // USB configuration and system outputs
  // ========================================================================
  assign BOOT_ACTIVE             = boot_mode && !exited;
  assign PULLUP_CONTROL_PORT_PIN = BOOT_ACTIVE && (state != S_WAIT_ENUM || USB_ENUMERATED)
                                   ; // R3
  assign TIMES_THREE_MULTIPLIER  = BOOT_ACTIVE && mode_x3; // R1
  assign TIMES_TWO_MULTIPLIER    = BOOT_ACTIVE && mode_x2; // R2
  assign SELF_POWERED            = strap_self; // R4
  assign MAX_POWER_MA            = strap_self ? `UBH_POWER_SELF : `UBH_POWER_BUS; // R4
  assign POWER_DOWN_INHIBIT      = BOOT_ACTIVE && !strap_self; // R6
  assign USB_VERSION             = `UBH_USB_VERSION; // R5
  assign CTRL_EP_MAX_PACKET      = `UBH_EP0_PACKET; // R5
  assign CONFIG_NUMBER           = `UBH_CONFIG_NUM; // R5
  assign INTERFACE_NUMBER        = `UBH_IFACE_NUM; // R5
  assign ALT_SETTING             = `UBH_ALT_SETTING; // R5
  // Interrupts are masked only while the erase runs; done or failed frees them.
  assign INT_DISABLE             = erasing && !erase_done && !erase_fail; // R22

  // ========================================================================
  // Register port
  // ========================================================================
  always @(posedge SYS_CLK or negedge ARST_N) begin
    if (!ARST_N) begin
      freq_tol  <= `UBH_FREQ_TOL_RESET;
      REG_RDATA <= 32'h00000000;
    end else begin
      if (REG_WR && (REG_ADDR == `UBH_REG_FREQ_TOL)) begin
        freq_tol <= REG_WDATA[15:0];
      end
      REG_RDATA <= 32'h00000000;
      if (REG_RD) begin
        case (REG_ADDR)
          `UBH_REG_FREQ_TOL:   REG_RDATA <= {16'h0000, freq_tol};
          `UBH_REG_STATUS:     REG_RDATA <= {24'h000000, erase_fail, erase_done,
                                             BOOT_ACTIVE, (state == S_HALT), state};
          `UBH_REG_RX_FREQ:    REG_RDATA <= {16'h0000, rx_freq};
          `UBH_REG_PROG_COUNT: REG_RDATA <= {16'h0000, prog_count};
          default:             REG_RDATA <= 32'h00000000;
        endcase
      end
    end
  end

endmodule // ubh_boot_handshake

// *** verification/ubh_boot_handshake_checker.sv ***
`timescale 1ns/10ps
// ==========
// Port checker
// ==========
module ubh_boot_handshake_checker (
  input wire       SYS_CLK,
  input wire       ARST_N,
  input wire       RX_READY,
  input wire [7:0] TX_DATA,
  input wire       TX_VALID,
  input wire       TX_READY,
  input wire       FLASH_ERASE_START,
  input wire       INT_DISABLE,
  input wire       BRANCH_REQ,
  input wire       WATCHDOG_TIMER_OVERFLOW,
  input wire       BOOT_ACTIVE,
  input wire       PULLUP_CONTROL_PORT_PIN,
  input wire       SELF_POWERED,
  input wire [8:0] MAX_POWER_MA,
  input wire       POWER_DOWN_INHIBIT
);
  default clocking cb @(posedge SYS_CLK);
  endclocking
  default disable iff (!ARST_N);

  sequence halt_sent;
    TX_VALID && TX_READY && (TX_DATA == 8'hff || TX_DATA == 8'hee);
  endsequence
  sequence done_sent;
    TX_VALID && TX_READY && TX_DATA == 8'h06;
  endsequence

  // A watchdog exit may drop an answer mid-wait, so it is excluded here.
  tx_hold_a :
    assert property (TX_VALID && !TX_READY && !WATCHDOG_TIMER_OVERFLOW
      |=> TX_VALID && $stable(TX_DATA)) else $error("Answer byte changed before taken");
  rx_block_a :
    assert property (TX_VALID |-> !RX_READY) else $error("Byte accepted while answering");
  halt_stop_a :
    assert property (halt_sent |=> !RX_READY [*4]) else $error("Input open after abort");
  branch_seq_a :
    assert property (done_sent |-> ##[1:3] BRANCH_REQ) else $error("No branch after erase");
  erase_int_a :
    assert property (FLASH_ERASE_START |-> ##[0:1] INT_DISABLE)
      else $error("Interrupts usable during erase");
  wdt_exit_a :
    assert property (WATCHDOG_TIMER_OVERFLOW |=> !BOOT_ACTIVE && !PULLUP_CONTROL_PORT_PIN)
      else $error("Watchdog did not end boot");
  pullup_gate_a :
    assert property (PULLUP_CONTROL_PORT_PIN |-> BOOT_ACTIVE) else $error("Stray pull-up");
  power_sel_a :
    assert property (BOOT_ACTIVE |-> MAX_POWER_MA == (SELF_POWERED ? 9'h064 : 9'h1f4))
      else $error("Wrong power figure");
  no_pdown_a :
    assert property (POWER_DOWN_INHIBIT == (BOOT_ACTIVE && !SELF_POWERED))
      else $error("Power-down inhibit wrong");
endmodule // ubh_boot_handshake_checker

// *** verification/ubh_host_model.sv ***
`timescale 1ns/10ps
// ==========
// Host end of the bulk byte pipes
// ==========
module ubh_host_model (
  input  wire       SYS_CLK,
  input  wire       RX_READY,
  input  wire [7:0] TX_DATA,
  input  wire       TX_VALID,
  output reg  [7:0] RX_DATA,
  output reg        RX_VALID,
  output reg        TX_READY
);
  initial begin
    RX_DATA = 8'h00;
    RX_VALID = 1'b0;
    TX_READY = 1'b0;
  end

  // The released data lines show the inverse so a stale byte never looks fresh.
  task send_byte(input [7:0] b);
    integer n;
    begin
      @(posedge SYS_CLK);
      RX_DATA <= b;
      RX_VALID <= 1'b1;
      n = 0;
      @(posedge SYS_CLK);
      while (RX_READY !== 1'b1 && n < 500) begin
        @(posedge SYS_CLK);
        n = n + 1;
      end
      RX_VALID <= 1'b0;
      RX_DATA <= ~b;
    end
  endtask

  // A slow host lets the answer wait before it is collected.
  task recv_byte(input integer stall, output [7:0] b);
    integer n;
    begin
      @(posedge SYS_CLK);
      repeat (stall) @(posedge SYS_CLK);
      TX_READY <= 1'b1;
      n = 0;
      @(posedge SYS_CLK);
      while (TX_VALID !== 1'b1 && n < 500) begin
        @(posedge SYS_CLK);
        n = n + 1;
      end
      b = (TX_VALID === 1'b1) ? TX_DATA : 8'hxx;
      TX_READY <= 1'b0;
    end
  endtask
endmodule // ubh_host_model

// *** verification/ubh_boot_handshake_tb.sv ***
`timescale 1ns/10ps
module ubh_boot_handshake_tb;
  logic        SYS_CLK, ARST_N, FLASH_WRITE_ENABLE_PIN, USB_POWER_MODE_SELECT, SMALL_RAM;
  logic        USB_ENUMERATED, FLASH_BLANK, FLASH_ERASE_DONE, FLASH_ERASE_FAIL;
  logic        WATCHDOG_TIMER_OVERFLOW, REG_WR, REG_RD;
  logic [2:0]  MODE_SELECT_PINS;
  logic [7:0]  REG_ADDR;
  logic [31:0] REG_WDATA;
  wire  [7:0]  RX_DATA, TX_DATA, RAM_WDATA, CONFIG_NUMBER, INTERFACE_NUMBER, ALT_SETTING;
  wire         RX_VALID, RX_READY, TX_VALID, TX_READY, RAM_WE, FLASH_ERASE_START;
  wire         INT_DISABLE, BRANCH_REQ, BOOT_ACTIVE, PULLUP_CONTROL_PORT_PIN;
  wire         TIMES_THREE_MULTIPLIER, TIMES_TWO_MULTIPLIER, SELF_POWERED, POWER_DOWN_INHIBIT;
  wire  [23:0] RAM_ADDR, BRANCH_ADDR;
  wire  [8:0]  MAX_POWER_MA;
  wire  [15:0] USB_VERSION;
  wire  [6:0]  CTRL_EP_MAX_PACKET;
  wire  [31:0] REG_RDATA;
  integer      miscompares = 0, total_checks = 0, stall = 0, ram_cnt, erase_cnt, br_cnt;
  logic [23:0] ram_addr;
  logic [7:0]  ram_data, got;

  ubh_boot_handshake ubh_boot_handshake_inst (.*);
  ubh_host_model ubh_host_model_inst (.*);

  initial begin
    SYS_CLK = 1'b0;
    forever #12.5 SYS_CLK = ~SYS_CLK;
  end

  always @(posedge SYS_CLK or negedge ARST_N) begin
    if (!ARST_N) begin
      ram_cnt <= 0;
      erase_cnt <= 0;
      br_cnt <= 0;
    end else begin
      if (RAM_WE === 1'b1) begin
        ram_cnt <= ram_cnt + 1;
        ram_addr <= RAM_ADDR;
        ram_data <= RAM_WDATA;
      end
      if (FLASH_ERASE_START === 1'b1) erase_cnt <= erase_cnt + 1;
      if (BRANCH_REQ === 1'b1) br_cnt <= br_cnt + 1;
    end
  end

  // ==========
  // Shared tasks
  // ==========
  task check(input [63:0] g, input [63:0] e);
    begin
      total_checks = total_checks + 1;
      if (g !== e) begin
        miscompares = miscompares + 1;
        $display("Error at %0t: got %h expected %h", $time, g, e);
      end
    end
  endtask
  task print_verdict;
    begin
      $display("Checks %0d, mismatches %0d", total_checks, miscompares);
      if (miscompares == 0 && total_checks > 0)
        $display("ALL TESTS PASSED");
      else
        $display("TESTS FAILED");
      $finish;
    end
  endtask
  task send(input [7:0] b);
    ubh_host_model_inst.send_byte(b);
  endtask
  task xfer(input [7:0] b, input [7:0] e);
    begin
      ubh_host_model_inst.send_byte(b);
      ubh_host_model_inst.recv_byte(stall, got);
      check(got, e);
    end
  endtask
  task reg_write(input [7:0] a, input [31:0] d);
    begin
      @(posedge SYS_CLK);
      REG_ADDR <= a;
      REG_WDATA <= d;
      REG_WR <= 1'b1;
      @(posedge SYS_CLK);
      REG_WR <= 1'b0;
    end
  endtask
  task reg_read(input [7:0] a, input [31:0] e);
    begin
      @(posedge SYS_CLK);
      REG_ADDR <= a;
      REG_RD <= 1'b1;
      @(posedge SYS_CLK);
      REG_RD <= 1'b0;
      #1;
      check(REG_RDATA, e);
    end
  endtask
  // Straps are set while reset is low and never touched again until the next reset.
  task reset_dut(input [2:0] m, input p, input s);
    begin
      ARST_N <= 1'b0;
      MODE_SELECT_PINS <= m;
      USB_POWER_MODE_SELECT <= p;
      SMALL_RAM <= s;
      USB_ENUMERATED <= 1'b0;
      repeat (20) @(posedge SYS_CLK);
      ARST_N <= 1'b1;
      repeat (8) @(posedge SYS_CLK);
      check(PULLUP_CONTROL_PORT_PIN, 1'b0);
      check({TIMES_THREE_MULTIPLIER, TIMES_TWO_MULTIPLIER}, {m == 3'h3, m == 3'h2});
      check({SELF_POWERED, MAX_POWER_MA, POWER_DOWN_INHIBIT}, {p, p ? 9'h064 : 9'h1f4, !p});
      check({USB_VERSION, CTRL_EP_MAX_PACKET, CONFIG_NUMBER, INTERFACE_NUMBER, ALT_SETTING},
            {16'h0110, 7'h40, 24'h010000});
      USB_ENUMERATED <= 1'b1;
      repeat (2) @(posedge SYS_CLK);
      check(PULLUP_CONTROL_PORT_PIN, 1'b1);
    end
  endtask
  task clk_info(input [15:0] f, input [7:0] c, input [7:0] e);
    begin
      xfer(8'h55, 8'haa);
      send(f[15:8]);
      send(f[7:0]);
      send(c);
      xfer(8'h01, e);
    end
  endtask
  task count(input [15:0] n, input [7:0] e);
    begin
      send(n[15:8]);
      xfer(n[7:0], e);
    end
  endtask
  task expect_halt;
    begin
      repeat (4) @(posedge SYS_CLK);
      check({RX_READY, br_cnt[7:0]}, 9'h000);
    end
  endtask

  // ==========
  // Scenarios
  // ==========
  task t_boot(input [2:0] m, input p, input s, input blank);
    reg [23:0] base;
    begin
      base = s ? 24'hffd000 : 24'hffc000;
      FLASH_BLANK <= blank;
      reset_dut(m, p, s);
      clk_info(m == 3'h3 ? 16'h0640 : 16'h0960, 8'h01, 8'haa);
      count(16'h0002, 8'haa);
      send(8'h5a);
      send(8'h3c);
      xfer(8'h6a, 8'haa);
      check({ram_cnt[7:0], ram_addr, ram_data}, {8'h02, base + 24'h1, 8'h3c});
      check(erase_cnt, !blank);
      if (!blank) begin
        check(INT_DISABLE, 1'b1);
        xfer(8'h3a, 8'h11);
        FLASH_ERASE_DONE <= 1'b1;
        @(posedge SYS_CLK);
        FLASH_ERASE_DONE <= 1'b0;
      end
      xfer(8'h3a, 8'h06);
      check(INT_DISABLE, 1'b0);
      repeat (4) @(posedge SYS_CLK);
      check({br_cnt[7:0], BRANCH_ADDR}, {8'h01, base});
      check(PULLUP_CONTROL_PORT_PIN, 1'b1);
    end
  endtask
  task t_clk_bad;
    begin
      reset_dut(3'h2, 1'b0, 1'b0);
      send(8'h54);
      repeat (2) @(posedge SYS_CLK);
      check({TX_VALID, RX_READY}, 2'h1);
      reset_dut(3'h2, 1'b0, 1'b0);
      clk_info(16'h0640, 8'h01, 8'hff);
      expect_halt;
      reset_dut(3'h3, 1'b1, 1'b0);
      clk_info(16'h0640, 8'h02, 8'hff);
      expect_halt;
    end
  endtask
  // The tolerance register widens the frequency window; counts probe both ends.
  task t_regs_count;
    begin
      reset_dut(3'h3, 1'b1, 1'b0);
      reg_read(8'h00, 32'h0);
      reg_write(8'h00, 32'h10);
      reg_write(8'h04, 32'hffffffff);
      reg_read(8'h00, 32'h10);
      reg_read(8'hfc, 32'h0);
      clk_info(16'h0650, 8'h01, 8'haa);
      count(16'h2001, 8'hff);
      expect_halt;
      reg_read(8'h0c, 32'h2001);
      reg_read(8'h04, 32'h3c);
      reset_dut(3'h2, 1'b0, 1'b1);
      clk_info(16'h0960, 8'h01, 8'haa);
      count(16'h1001, 8'hff);
      expect_halt;
      reset_dut(3'h3, 1'b0, 1'b0);
      clk_info(16'h0640, 8'h01, 8'haa);
      count(16'h0000, 8'hff);
      expect_halt;
    end
  endtask
  task t_abort;
    begin
      FLASH_BLANK <= 1'b0;
      reset_dut(3'h3, 1'b0, 1'b0);
      clk_info(16'h0640, 8'h01, 8'haa);
      count(16'h0001, 8'haa);
      send(8'h01);
      xfer(8'h00, 8'hff);
      expect_halt;
      reset_dut(3'h3, 1'b0, 1'b0);
      clk_info(16'h0640, 8'h01, 8'haa);
      count(16'h0001, 8'haa);
      send(8'h01);
      xfer(8'hff, 8'haa);
      FLASH_ERASE_FAIL <= 1'b1;
      @(posedge SYS_CLK);
      FLASH_ERASE_FAIL <= 1'b0;
      xfer(8'h3a, 8'hee);
      expect_halt;
    end
  endtask
  task t_wdt;
    begin
      reset_dut(3'h2, 1'b1, 1'b0);
      clk_info(16'h0960, 8'h01, 8'haa);
      @(posedge SYS_CLK);
      WATCHDOG_TIMER_OVERFLOW <= 1'b1;
      @(posedge SYS_CLK);
      WATCHDOG_TIMER_OVERFLOW <= 1'b0;
      @(posedge SYS_CLK);
      check({BOOT_ACTIVE, PULLUP_CONTROL_PORT_PIN, RX_READY, TIMES_TWO_MULTIPLIER}, 4'h0);
    end
  endtask

  initial begin
    ARST_N = 1'b0;
    FLASH_WRITE_ENABLE_PIN = 1'b1;
    MODE_SELECT_PINS = 3'h3;
    USB_POWER_MODE_SELECT = 1'b1;
    SMALL_RAM = 1'b0;
    USB_ENUMERATED = 1'b0;
    FLASH_BLANK = 1'b0;
    FLASH_ERASE_DONE = 1'b0;
    FLASH_ERASE_FAIL = 1'b0;
    WATCHDOG_TIMER_OVERFLOW = 1'b0;
    REG_WR = 1'b0;
    REG_RD = 1'b0;
    REG_ADDR = 8'h00;
    REG_WDATA = 32'h0;
    @(posedge SYS_CLK);
    t_boot(3'h3, 1'b1, 1'b0, 1'b0);
    stall = 3;
    t_boot(3'h2, 1'b0, 1'b1, 1'b1);
    stall = 0;
    t_clk_bad;
    t_regs_count;
    t_abort;
    t_wdt;
    print_verdict;
  end

  initial begin
    #(25 * 40000);
    miscompares = miscompares + 1;
    print_verdict;
  end
endmodule // ubh_boot_handshake_tb

bind ubh_boot_handshake ubh_boot_handshake_checker ubh_boot_handshake_checker_inst (.*);
